// *** hbc_pkg.sv ***
/*
  Shared constants and types of the H-bridge control block: the register map,
  the field layout, the reset values and the timing counts.
  Assumes a 125 MHz system clock. All analog detection is done by comparators
  outside the block, which deliver synchronous logic levels.
*/
package hbc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Break-before-make gap between the two switches of one leg.
  localparam int unsigned DEAD_TIME_NS  = 500;
  localparam int unsigned DEAD_CYCLES   =
    (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal chopping rate, typical value of the allowed band.
  localparam int unsigned CHOP_RATE_HZ  = 46_000;
  localparam int unsigned CHOP_CYCLES   = CLK_HZ / CHOP_RATE_HZ;

  localparam int unsigned DEAD_W = 7;
  localparam int unsigned CHOP_W = 12;
  localparam logic [DEAD_W-1:0] DEAD_LAST = DEAD_W'(DEAD_CYCLES);
  localparam logic [CHOP_W-1:0] CHOP_LAST = CHOP_W'(CHOP_CYCLES - 1);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;

  localparam int unsigned CTRL_CHOP_EN_BIT  = 0;
  localparam int unsigned CTRL_HOLD_OFF_BIT = 1;
  localparam logic [1:0]  CTRL_RESET        = 2'h1;

  localparam int unsigned STAT_FAULT_BIT  = 0;
  localparam int unsigned STAT_CAUSE_LSB  = 1;
  localparam int unsigned STAT_GATE_LSB   = 8;
  localparam int unsigned STAT_CHOP_BIT   = 12;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic legAHighSwitch;
    logic legALowSwitch;
    logic legBHighSwitch;
    logic legBLowSwitch;
  } hbc_gate_t;

  typedef struct packed {
    logic supplyLow;
    logic overheat;
    logic overcurrent;
    logic shortCircuit;
  } hbc_cause_t;

  typedef enum logic {CHOP_ON, CHOP_OFF} hbc_chop_t;

endpackage

// *** hbc_bridge_ctrl.sv ***
/*
  Gate control of a brushed DC motor H-bridge: direction decode, own
  break-before-make gap, low-side chopping for peak current limiting, the
  protection latch with its fault output, and a small APB register slave.
  Assumes all inputs synchronous to clk_sys and the detector inputs to come
  from comparators outside. The block reset stands for the control-supply
  power-on reset.
*/
// Contract
// - Direction input A low: leg A high on, low off; high: the reverse.
// - Direction input B low: leg B high on, low off; high: the reverse.
// - Enable low, directions not both low: all bridge switches held off.
// - Drive needs enable high; A high B low forward, A low B high reverse.
// - Own dead time between the two switches of a leg on reversal.
// - Both direction inputs low: both high-side switches on for braking.
// - Enable may carry host PWM up to 50 kHz gating the outputs.
// - Enable pulses down to 1 us are followed correctly.
// - Any detector trip drives fault low and latches all switches off.
// - Protection latch stays set until power-on reset.
// - Supply falling while enable is high asserts the fault output.
// - Current limited by chopping only low-side switches at internal rate.
// - Overcurrent detector trip shuts off and latches the outputs.
// - Chopping on-phase ends when sense reaches the set level.
// - Short-circuit detection works even with the sense resistor shorted.
module hbc_bridge_ctrl
  import hbc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              dirInA,
  input  wire logic              dirInB,
  input  wire logic              enableIn,
  input  wire logic              shortDetect,
  input  wire logic              overcurrentDetect,
  input  wire logic              overheatDetect,
  input  wire logic              peakReached,
  input  wire logic              supplyLow,
  output hbc_gate_t              gate,
  output logic                   faultN
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  // Returns {high, low} requests for one leg from its own direction input.
  function automatic logic [1:0] legRequest(input logic dirIn,
                                            input logic bothLow,
                                            input logic enable);
    logic [1:0] req;
    req = 2'h0;
    if (bothLow) begin
      req = 2'h2;
    end else if (enable) begin
      req = dirIn ? 2'h1 : 2'h2;
    end
    return req;
  endfunction

  function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    return addr == offset;
  endfunction

  // ****************************************************************
  // Protection latch
  // ****************************************************************
  hbc_cause_t cause_q;
  hbc_cause_t cause_d;
  logic       faultLatch_q;
  logic       faultLatch_d;
  logic       faultN_q;
  logic       faultN_d;

  always_comb begin
    cause_d = cause_q;
    // Sticky causes; nothing but reset clears them.
    if (shortDetect) begin
      cause_d.shortCircuit = 1'b1;
    end
    if (overcurrentDetect) begin
      cause_d.overcurrent = 1'b1;
    end
    if (overheatDetect) begin
      cause_d.overheat = 1'b1;
    end
    if (supplyLow && enableIn) begin
      cause_d.supplyLow = 1'b1;
    end
    faultLatch_d = faultLatch_q | (|cause_d);
    faultN_d     = ~faultLatch_d;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cause_q      <= '0;
      faultLatch_q <= 1'b0;
      faultN_q     <= 1'b1;
    end else begin
      cause_q      <= cause_d;
      faultLatch_q <= faultLatch_d;
      faultN_q     <= faultN_d;
    end
  end

  assign faultN = faultN_q;

  // ****************************************************************
  // Control register and chopping oscillator
  // ****************************************************************
  logic [1:0]        ctrl_q;
  logic [1:0]        ctrl_d;
  hbc_chop_t         chop_q;
  hbc_chop_t         chop_d;
  logic [CHOP_W-1:0] chopCnt_q;
  logic [CHOP_W-1:0] chopCnt_d;
  logic              chopEn;
  logic              lowAllowed;
  logic              apbWrite;

  assign chopEn   = ctrl_q[CTRL_CHOP_EN_BIT];
  assign apbWrite = psel && penable && pready && pwrite;

  always_comb begin
    ctrl_d = ctrl_q;
    if (apbWrite && addrHit(paddr, CTRL_OFFSET)) begin
      ctrl_d = pwdata[1:0];
    end
    chopCnt_d = (chopCnt_q == CHOP_LAST) ? '0 : chopCnt_q + 1'b1;
    chop_d    = chop_q;
    // A peak in the on-phase wins over a period start in the same cycle.
    case (chop_q)
      CHOP_ON: begin
        if (peakReached) begin
          chop_d = CHOP_OFF;
        end
      end
      CHOP_OFF: begin
        if (chopCnt_q == CHOP_LAST) begin
          chop_d = CHOP_ON;
        end
      end
      default: begin
        chop_d = CHOP_ON;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_q    <= CTRL_RESET;
      chop_q    <= CHOP_ON;
      chopCnt_q <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      chop_q    <= chop_d;
      chopCnt_q <= chopCnt_d;
    end
  end

  assign lowAllowed = !chopEn || (chop_q == CHOP_ON);

  // ****************************************************************
  // Bridge legs with break-before-make
  // ****************************************************************
  logic [1:0] dirIn;
  logic [1:0] hiOn_q;
  logic [1:0] loOn_q;
  logic [1:0] hiOn_d;
  logic [1:0] loOn_d;
  logic [1:0] lastLow_q;
  logic [1:0] lastLow_d;
  logic       bothLow;
  logic       drive;

  assign dirIn   = {dirInB, dirInA};
  assign bothLow = !dirInA && !dirInB;
  // Enable is looked at every cycle, so host PWM of any width is followed.
  assign drive   = !faultLatch_d && !ctrl_q[CTRL_HOLD_OFF_BIT];

  genvar leg;
  generate
    for (leg = 0; leg < 2; leg++) begin : g_leg
      logic [DEAD_W-1:0] offCnt_q;
      logic [DEAD_W-1:0] offCnt_d;
      logic [1:0]        req;
      logic              gapDone;

      always_comb begin
        req      = drive ? legRequest(dirIn[leg], bothLow, enableIn)
                         : 2'h0;
        gapDone  = (offCnt_q == DEAD_LAST);
        offCnt_d = (hiOn_q[leg] || loOn_q[leg]) ? '0 :
                   (gapDone ? offCnt_q : offCnt_q + 1'b1);
        // A side may turn on only after the gap unless it was the last one on.
        hiOn_d[leg] = req[1] && !loOn_q[leg] && (!lastLow_q[leg] || gapDone);
        loOn_d[leg] = req[0] && lowAllowed && !hiOn_q[leg]
                      && (lastLow_q[leg] || gapDone);
        lastLow_d[leg] = hiOn_q[leg] ? 1'b0 : (loOn_q[leg] ? 1'b1 : lastLow_q[leg]);
      end

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          offCnt_q <= DEAD_LAST;
        end else begin
          offCnt_q <= offCnt_d;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hiOn_q    <= 2'h0;
      loOn_q    <= 2'h0;
      lastLow_q <= 2'h0;
    end else begin
      hiOn_q    <= hiOn_d;
      loOn_q    <= loOn_d;
      lastLow_q <= lastLow_d;
    end
  end

  assign gate = '{legAHighSwitch: hiOn_q[0], legALowSwitch: loOn_q[0],
                  legBHighSwitch: hiOn_q[1], legBLowSwitch: loOn_q[1]};

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;

  // Answer is prepared in the setup cycle and shown in the first access cycle.
  always_comb begin
    pready_d  = psel && !penable;
    prdata_d  = READ_ZERO;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      if (addrHit(paddr, CTRL_OFFSET)) begin
        prdata_d[1:0] = ctrl_q;
      end else if (addrHit(paddr, STATUS_OFFSET)) begin
        prdata_d[STAT_FAULT_BIT]                     = faultLatch_q;
        prdata_d[STAT_CAUSE_LSB +: 4]                = cause_q;
        prdata_d[STAT_GATE_LSB +: 4]                 = gate;
        prdata_d[STAT_CHOP_BIT]                      = (chop_q == CHOP_OFF);
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_q  <= READ_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_latch_holds:
    assert property (faultLatch_q |=> faultLatch_q && !faultN)
    else $error("Protection latch released without reset.");

  a_trip_fault_low:
    assert property ((shortDetect || overcurrentDetect || overheatDetect)
                     |=> !faultN && (gate == '0))
    else $error("Detector trip did not pull fault low and switches off.");

  a_supply_fault:
    assert property ((supplyLow && enableIn) |=> !faultN)
    else $error("Supply fall under enable did not assert fault.");

  a_leg_no_overlap:
    assert property (!(gate.legAHighSwitch && gate.legALowSwitch)
                     && !(gate.legBHighSwitch && gate.legBLowSwitch))
    else $error("Both switches of one leg are on.");

  a_dead_gap_a:
    assert property ($fell(gate.legAHighSwitch) |-> !gate.legALowSwitch [*8])
    else $error("Leg A low switch turned on inside the gap.");

  a_enable_off:
    assert property ((!enableIn && (dirInA || dirInB)) |=> (gate == '0))
    else $error("Switches on with enable low.");

  a_brake_high:
    assert property ((gate.legAHighSwitch && gate.legBHighSwitch)
                     |-> $past(!dirInA && !dirInB))
    else $error("Both high switches on without brake request.");

  a_dir_map:
    assert property ((gate.legALowSwitch |-> $past(dirInA && enableIn))
                     and (gate.legBLowSwitch |-> $past(dirInB && enableIn)))
    else $error("Low switch on against its direction input.");

  a_chop_low_only:
    assert property ((chopEn && chop_q == CHOP_OFF)
                     |=> !gate.legALowSwitch && !gate.legBLowSwitch)
    else $error("Low switch on during chopping off-phase.");

  a_peak_ends_on:
    assert property ((chop_q == CHOP_ON && peakReached) |=> chop_q == CHOP_OFF)
    else $error("Peak did not end the chopping on-phase.");

endmodule

// *** hbc_host_model.sv ***
/*
  Host controller model: drives the two direction inputs and enable,
  with an optional enable PWM.
  Assumes the bench selects the mode and switches the PWM on and off.
*/
module hbc_host_model #(
  parameter int PWM_PERIOD = 2500,
  parameter int PWM_HIGH   = 2375
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  input  wire logic       pwmEn,
  output logic            dirInA,
  output logic            dirInB,
  output logic            enableIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Drive
  // ****************************************************************
  // Modes: 0 stop, 1 forward, 2 reverse, 3 brake.
  // The PWM runs at 50 kHz with a 1 us low pulse and a long high pulse.
  int pwmCnt;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwmCnt   <= 0;
      dirInA   <= 1'b1;
      dirInB   <= 1'b1;
      enableIn <= 1'b0;
    end else begin
      pwmCnt   <= (pwmCnt == PWM_PERIOD - 1) ? 0 : pwmCnt + 1;
      dirInA   <= mode != 2'd2 && mode != 2'd3;
      dirInB   <= mode == 2'd0 || mode == 2'd2;
      enableIn <= (mode == 2'd1 || mode == 2'd2)
                  && (!pwmEn || pwmCnt < PWM_HIGH);
    end
  end
endmodule

// *** hbc_bridge_ctrl_tb_top.sv ***
/*
  Self-checking bench of the H-bridge control block.
  Assumes the host model drives direction and enable; the bench drives
  APB and the detector inputs.
*/
module hbc_bridge_ctrl_tb_top import hbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic              peakReached = 1'b0;
  logic              pwmEn = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic [31:0]       prdata;
  logic [31:0]       rd;
  logic              pready;
  logic              pslverr;
  logic              err;
  logic              faultN;
  logic              dirInA;
  logic              dirInB;
  logic              enableIn;
  logic [3:0]        det = 4'h0;
  logic [1:0]        mode = 2'd0;
  hbc_gate_t         gate;
  int                miscompares = 0;
  int                nCompared = 0;

  always #4 clk_sys = ~clk_sys;

  hbc_bridge_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dirInA(dirInA), .dirInB(dirInB), .enableIn(enableIn),
    .shortDetect(det[0]), .overcurrentDetect(det[1]), .overheatDetect(det[2]),
    .peakReached(peakReached), .supplyLow(det[3]), .gate(gate), .faultN(faultN));

  hbc_host_model u_host (.clk_sys(clk_sys), .rst(rst), .mode(mode), .pwmEn(pwmEn),
    .dirInA(dirInA), .dirInB(dirInB), .enableIn(enableIn));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'h0000_0001, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(exp, rd);
  endtask

  task automatic gate_wait(input logic [3:0] exp, input int max);
    int n = 0;
    while (gate !== exp && n < max) begin
      @(posedge clk_sys);
      n++;
    end
    chk({28'h0, exp}, {28'h0, gate});
  endtask

  task automatic wait_en(input logic v);
    int n = 0;
    while (enableIn !== v && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk({31'h0, v}, {31'h0, enableIn});
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    mode <= 2'd0;
    cyc(10);
    rst <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cyc(50000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(2);
    chk(32'h0000_0001, {31'h0, faultN});
    chk(32'h0000_0000, {28'h0, gate});
    rdchk(CTRL_OFFSET, 32'h0000_0001);
    rdchk(STATUS_OFFSET, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(32'h0000_0001, {31'h0, err});
    $display("test registers done");
    mode <= 2'd1;
    gate_wait(4'b0110, 80);
    mode <= 2'd2;
    cyc(4);
    chk(32'h0000_0000, {28'h0, gate});
    cyc(50);
    chk(32'h0000_0000, {28'h0, gate});
    gate_wait(4'b1001, 40);
    mode <= 2'd3;
    gate_wait(4'b1010, 80);
    mode <= 2'd0;
    gate_wait(4'b0000, 4);
    $display("test direction done");
    mode <= 2'd1;
    gate_wait(4'b0110, 80);
    // Peak without an overcurrent trip: the set level stays below the trip level.
    @(posedge clk_sys) peakReached <= 1'b1;
    @(posedge clk_sys) peakReached <= 1'b0;
    cyc(3);
    chk(32'h0000_0002, {28'h0, gate});
    gate_wait(4'b0110, 2800);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
    rdchk(CTRL_OFFSET, 32'h0000_0000);
    @(posedge clk_sys) peakReached <= 1'b1;
    @(posedge clk_sys) peakReached <= 1'b0;
    cyc(3);
    chk(32'h0000_0006, {28'h0, gate});
    // The off-phase started above still runs when chopping is enabled again.
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    gate_wait(4'b0010, 4);
    rdchk(STATUS_OFFSET, 32'h0000_1200);
    gate_wait(4'b0110, 2800);
    apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF);
    rdchk(STATUS_OFFSET, 32'h0000_0600);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0003);
    gate_wait(4'b0000, 4);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0001);
    gate_wait(4'b0110, 4);
    $display("test chopping done");
    pwmEn <= 1'b1;
    wait_en(1'b0);
    cyc(3);
    chk(32'h0000_0000, {28'h0, gate});
    wait_en(1'b1);
    cyc(3);
    chk(32'h0000_0006, {28'h0, gate});
    pwmEn <= 1'b0;
    $display("test pwm done");
    for (int i = 0; i < 4; i++) begin
      do_reset();
      mode <= 2'd1;
      gate_wait(4'b0110, 80);
      @(posedge clk_sys) det <= 4'(1 << i);
      @(posedge clk_sys) det <= 4'h0;
      cyc(2);
      chk(32'h0000_0000, {31'h0, faultN});
      chk(32'h0000_0000, {28'h0, gate});
      cyc(20);
      chk(32'h0000_0000, {31'h0, faultN});
      chk(32'h0000_0000, {28'h0, gate});
      rdchk(STATUS_OFFSET, 32'(1 + (2 << i)));
    end
    do_reset();
    cyc(2);
    chk(32'h0000_0001, {31'h0, faultN});
    chk(32'h0000_0000, {28'h0, gate});
    $display("test faults done");
    tally_and_finish();
  end
endmodule
